// *** verilog/spsc_pkg.sv ***
// Package with register map, field layout, reset values and carrier types of the suspend pin block.
package spsc_pkg;

  localparam int SPSC_ADDR_W = 10;
  localparam int SPSC_DATA_W = 16;

  localparam logic [9:0] SPSC_OFS_LEVELS = 10'h06a;
  localparam logic [9:0] SPSC_OFS_DRIVE = 10'h06b;
  localparam logic [9:0] SPSC_OFS_REVISION = 10'h260;
  localparam logic [9:0] SPSC_OFS_INDICATOR = 10'h262;

  localparam int SPSC_PIN_CLK = 0;
  localparam int SPSC_PIN_RTS = 1;
  localparam int SPSC_PIN_CTS = 2;
  localparam int SPSC_PIN_XCVR_EN = 3;
  localparam int SPSC_PIN_TX = 6;
  localparam int SPSC_PIN_RX = 7;
  localparam int SPSC_PIN_CD = 10;
  localparam int SPSC_PIN_RI = 11;
  localparam int SPSC_PIN_DTR = 12;
  localparam int SPSC_PIN_DSR = 13;
  localparam int SPSC_OVR_EN_BIT = 15;

  localparam logic [15:0] SPSC_PIN_MASK = 16'h3ccf;

  localparam int SPSC_IND_B_LIVE_BIT = 13;
  localparam int SPSC_IND_B_SEL_LSB = 10;
  localparam int SPSC_IND_B_DRV_LSB = 8;
  localparam int SPSC_IND_A_LIVE_BIT = 5;
  localparam int SPSC_IND_A_SEL_LSB = 2;
  localparam int SPSC_IND_A_DRV_LSB = 0;

  localparam logic [15:0] SPSC_LEVELS_RST = 16'h0000;
  localparam logic [15:0] SPSC_DRIVE_RST = 16'h0000;
  localparam logic [2:0] SPSC_SEL_RST = 3'h0;
  localparam logic [1:0] SPSC_IND_DRV_RST = 2'h2;

  localparam logic [2:0] SPSC_SEL_SUSP_OR_RESET = 3'h0;
  localparam logic [2:0] SPSC_SEL_SUSP_ONLY = 3'h1;
  localparam logic [2:0] SPSC_SEL_POWER_CLASS = 3'h2;

  localparam logic [1:0] SPSC_DRV_OPEN_DRAIN = 2'h1;
  localparam logic [1:0] SPSC_DRV_ACTIVE = 2'h2;

  typedef enum logic [1:0] {SPSC_NORMAL, SPSC_HOLD, SPSC_FORCE} spsc_mode_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [9:0] addr;
    logic [15:0] wdata;
  } spsc_bus_req_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } spsc_pins_t;

  typedef struct packed {
    logic suspend;
    logic bus_reset;
    logic configured;
    logic high_power;
  } spsc_usb_t;

  typedef struct packed {
    logic out;
    logic oe;
  } spsc_ind_t;

endpackage

// *** verilog/spsc_indicator.sv ***
// USB state indicator pin: selects its assertion condition and its output driver type.
`timescale 1ns/1ps
module spsc_indicator
  import spsc_pkg::*;
#(
  parameter bit LOW_IN_DEFAULT = 1'b0
)
(
  input wire logic [2:0] sel,
  input wire logic [1:0] drive,
  input wire spsc_usb_t usb,
  output spsc_ind_t pin
);

  logic level;

  always_comb
  begin
    level = 1'b0;
    case (sel)
      SPSC_SEL_SUSP_OR_RESET:
      begin
        level = (usb.suspend | usb.bus_reset) ^ LOW_IN_DEFAULT;
      end
      SPSC_SEL_SUSP_ONLY:
      begin
        level = usb.suspend;
      end
      SPSC_SEL_POWER_CLASS:
      begin
        level = usb.suspend | (usb.high_power & ~usb.configured);
      end
      default:
      begin
        level = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    pin.out = 1'b0;
    pin.oe = 1'b0;
    case (drive)
      SPSC_DRV_ACTIVE:
      begin
        pin.out = level;
        pin.oe = 1'b1;
      end
      SPSC_DRV_OPEN_DRAIN:
      begin
        pin.out = 1'b0;
        pin.oe = ~level;
      end
      default:
      begin
        pin.out = 1'b0;
        pin.oe = 1'b0;
      end
    endcase
  end

endmodule // spsc_indicator

// *** verilog/spsc_ctrl.sv ***
// Suspend pin override and USB state indicator control with its register port.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

// Behaviour
// - Override off: pins keep their present output through suspend.
// - Override on: suspend entry forces programmed level and drive type per pin.
// - Level register holds one bit per pin at fixed positions; zero gives low.
// - A level bit of one drives the pin high, or releases an open drain pin, during overridden suspend.
// - Drive register same positions; zero drives actively, one is open drain.
// - Indicator register bit 13 returns the live second indicator pin level.
// - Indicator register bit 5 returns the live first indicator pin level.
// - Second select 000: second indicator high in suspend or bus reset.
// - Second select 001: second indicator high only in suspend.
// - Select 010: high in suspend, or unconfigured for a high power device.
// - First select 000: first indicator low in suspend or bus reset.
// - First select 001: first indicator high only in suspend.
// - Second drive field 01 open drain, 10 active; 00 and 11 invalid.
// - First drive field 10 active, 01 open drain; 00 and 11 invalid.
module spsc_ctrl
  import spsc_pkg::*;
#(
  parameter logic [15:0] REVISION_VALUE = 16'h00a5
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire spsc_bus_req_t bus_req,
  output logic [15:0] rd_data,
  input wire spsc_usb_t usb,
  input wire spsc_pins_t normal_pins,
  output spsc_pins_t gpio_pins,
  output logic usb_indicator_a_out,
  output logic usb_indicator_a_oe,
  input wire logic usb_indicator_a_in,
  output logic usb_indicator_b_out,
  output logic usb_indicator_b_oe,
  input wire logic usb_indicator_b_in
);

  // The revision value is arbitrary.

  typedef struct packed {
    spsc_mode_t mode;
    logic [15:0] levels;
    logic [15:0] drive;
    logic ovr_en;
    logic [2:0] sel_a;
    logic [1:0] drv_a;
    logic [2:0] sel_b;
    logic [1:0] drv_b;
    spsc_pins_t pins;
    spsc_ind_t ind_a;
    spsc_ind_t ind_b;
    logic [15:0] rdata;
  } spsc_state_t;

  localparam spsc_state_t SPSC_STATE_RST = '{
    mode: SPSC_NORMAL,
    levels: SPSC_LEVELS_RST,
    drive: SPSC_DRIVE_RST,
    ovr_en: 1'b0,
    sel_a: SPSC_SEL_RST,
    drv_a: SPSC_IND_DRV_RST,
    sel_b: SPSC_SEL_RST,
    drv_b: SPSC_IND_DRV_RST,
    pins: '{out: 16'h0000, oe: 16'h0000},
    ind_a: '{out: 1'b0, oe: 1'b0},
    ind_b: '{out: 1'b0, oe: 1'b0},
    rdata: 16'h0000
  };

  spsc_state_t state_ff;
  spsc_state_t nxt_state;
  spsc_pins_t forced_pins;
  spsc_ind_t ind_a_pin;
  spsc_ind_t ind_b_pin;
  logic [15:0] indicator_word;
  logic [15:0] drive_word;
  logic hit_levels;
  logic hit_drive;
  logic hit_revision;
  logic hit_indicator;

  // Forced value of each pin while the override holds it in suspend.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_force
      if (SPSC_PIN_MASK[gi])
      begin : g_used
        always_comb
        begin
          if (state_ff.drive[gi])
          begin
            forced_pins.out[gi] = 1'b0;
            forced_pins.oe[gi] = ~state_ff.levels[gi];
          end
          else
          begin
            forced_pins.out[gi] = state_ff.levels[gi];
            forced_pins.oe[gi] = 1'b1;
          end
        end
      end
      else
      begin : g_unused
        assign forced_pins.out[gi] = 1'b0;
        assign forced_pins.oe[gi] = 1'b0;
      end
    end
  endgenerate

  spsc_indicator #(
    .LOW_IN_DEFAULT(1'b1)
  ) u_ind_a (
    .sel(state_ff.sel_a),
    .drive(state_ff.drv_a),
    .usb(usb),
    .pin(ind_a_pin)
  );

  spsc_indicator #(
    .LOW_IN_DEFAULT(1'b0)
  ) u_ind_b (
    .sel(state_ff.sel_b),
    .drive(state_ff.drv_b),
    .usb(usb),
    .pin(ind_b_pin)
  );

  always_comb
  begin
    hit_levels = 1'b0;
    hit_drive = 1'b0;
    hit_revision = 1'b0;
    hit_indicator = 1'b0;
    if (bus_req.addr == SPSC_OFS_LEVELS)
    begin
      hit_levels = 1'b1;
    end
    else if (bus_req.addr == SPSC_OFS_DRIVE)
    begin
      hit_drive = 1'b1;
    end
    else if (bus_req.addr == SPSC_OFS_REVISION)
    begin
      hit_revision = 1'b1;
    end
    else if (bus_req.addr == SPSC_OFS_INDICATOR)
    begin
      hit_indicator = 1'b1;
    end
  end

  always_comb
  begin
    drive_word = state_ff.drive;
    drive_word[SPSC_OVR_EN_BIT] = state_ff.ovr_en;
    indicator_word = 16'h0000;
    indicator_word[SPSC_IND_B_LIVE_BIT] = usb_indicator_b_in;
    indicator_word[SPSC_IND_B_SEL_LSB +: 3] = state_ff.sel_b;
    indicator_word[SPSC_IND_B_DRV_LSB +: 2] = state_ff.drv_b;
    indicator_word[SPSC_IND_A_LIVE_BIT] = usb_indicator_a_in;
    indicator_word[SPSC_IND_A_SEL_LSB +: 3] = state_ff.sel_a;
    indicator_word[SPSC_IND_A_DRV_LSB +: 2] = state_ff.drv_a;
  end

  always_comb
  begin
    nxt_state = state_ff;

    // Register writes; reserved bits are not stored and read back as zero.
    if (bus_req.we)
    begin
      if (hit_levels)
      begin
        nxt_state.levels = bus_req.wdata & SPSC_PIN_MASK;
      end
      else if (hit_drive)
      begin
        nxt_state.drive = bus_req.wdata & SPSC_PIN_MASK;
        nxt_state.ovr_en = bus_req.wdata[SPSC_OVR_EN_BIT];
      end
      else if (hit_indicator)
      begin
        nxt_state.sel_b = bus_req.wdata[SPSC_IND_B_SEL_LSB +: 3];
        nxt_state.drv_b = bus_req.wdata[SPSC_IND_B_DRV_LSB +: 2];
        nxt_state.sel_a = bus_req.wdata[SPSC_IND_A_SEL_LSB +: 3];
        nxt_state.drv_a = bus_req.wdata[SPSC_IND_A_DRV_LSB +: 2];
      end
    end

    // Read data stand for exactly the cycle after the read strobe.
    nxt_state.rdata = 16'h0000;
    if (bus_req.re)
    begin
      if (hit_levels)
      begin
        nxt_state.rdata = state_ff.levels;
      end
      else if (hit_drive)
      begin
        nxt_state.rdata = drive_word;
      end
      else if (hit_revision)
      begin
        nxt_state.rdata = REVISION_VALUE;
      end
      else if (hit_indicator)
      begin
        nxt_state.rdata = indicator_word;
      end
    end

    // Suspend sequencing of the serial channel pins.
    case (state_ff.mode)
      SPSC_NORMAL:
      begin
        nxt_state.pins.out = normal_pins.out & SPSC_PIN_MASK;
        nxt_state.pins.oe = normal_pins.oe & SPSC_PIN_MASK;
        if (usb.suspend)
        begin
          if (state_ff.ovr_en)
          begin
            nxt_state.mode = SPSC_FORCE;
            nxt_state.pins = forced_pins;
          end
          else
          begin
            nxt_state.mode = SPSC_HOLD;
            nxt_state.pins = state_ff.pins;
          end
        end
      end
      SPSC_HOLD:
      begin
        nxt_state.pins = state_ff.pins;
        if (!usb.suspend)
        begin
          nxt_state.mode = SPSC_NORMAL;
          nxt_state.pins.out = normal_pins.out & SPSC_PIN_MASK;
          nxt_state.pins.oe = normal_pins.oe & SPSC_PIN_MASK;
        end
      end
      SPSC_FORCE:
      begin
        nxt_state.pins = forced_pins;
        if (!usb.suspend)
        begin
          nxt_state.mode = SPSC_NORMAL;
          nxt_state.pins.out = normal_pins.out & SPSC_PIN_MASK;
          nxt_state.pins.oe = normal_pins.oe & SPSC_PIN_MASK;
        end
      end
      default:
      begin
        nxt_state.mode = SPSC_NORMAL;
      end
    endcase

    nxt_state.ind_a = ind_a_pin;
    nxt_state.ind_b = ind_b_pin;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= SPSC_STATE_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data = state_ff.rdata;
  assign gpio_pins = state_ff.pins;
  assign usb_indicator_a_out = state_ff.ind_a.out;
  assign usb_indicator_a_oe = state_ff.ind_a.oe;
  assign usb_indicator_b_out = state_ff.ind_b.out;
  assign usb_indicator_b_oe = state_ff.ind_b.oe;

endmodule // spsc_ctrl

// *** tb/spsc_board.sv ***
// Board model of the two indicator lines with their pull-ups.
`timescale 1ns/1ps
module spsc_board
(
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  output logic a_in,
  output logic b_in
);
  // A released line floats up to the pull-up level.
  assign a_in = a_oe ? a_out : 1'b1;
  assign b_in = b_oe ? b_out : 1'b1;
endmodule // spsc_board

// *** tb/spsc_ctrl_chk.sv ***
// Port checker of the suspend pin block.
`timescale 1ns/1ps
module spsc_ctrl_chk
  import spsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire spsc_bus_req_t bus_req,
  input wire logic [15:0] rd_data,
  input wire spsc_usb_t usb,
  input wire spsc_pins_t normal_pins,
  input wire spsc_pins_t gpio_pins,
  input wire logic usb_indicator_a_out,
  input wire logic usb_indicator_a_oe,
  input wire logic usb_indicator_a_in,
  input wire logic usb_indicator_b_out,
  input wire logic usb_indicator_b_oe,
  input wire logic usb_indicator_b_in
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] cfg_ff;
  logic ok_ff;
  logic sr;
  assign sr = usb.suspend | usb.bus_reset;
  // Shadow of the indicator word, and a flag set once outputs left reset.
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      cfg_ff <= 16'h0202;
      ok_ff <= 1'b0;
    end
    else
    begin
      ok_ff <= 1'b1;
      if (bus_req.we && bus_req.addr == SPSC_OFS_INDICATOR)
        cfg_ff <= bus_req.wdata;
    end
  property p_norm; ok_ff && !$past(usb.suspend) |-> gpio_pins == ($past(normal_pins) & {2{SPSC_PIN_MASK}}); endproperty
  a_norm: assert property (p_norm) else $error("normal pin drive wrong");
  property p_hold;
    ok_ff && $past(usb.suspend, 2) && $past(usb.suspend) && !$past(bus_req.we, 2) |-> $stable(gpio_pins);
  endproperty
  a_hold: assert property (p_hold) else $error("suspend pins moved");
  property p_bsr; ok_ff && $past(cfg_ff[12:8]) == 5'h02 |-> usb_indicator_b_out == $past(sr); endproperty
  a_bsr: assert property (p_bsr) else $error("b suspend or reset");
  property p_bs; ok_ff && $past(cfg_ff[12:8]) == 5'h06 |-> usb_indicator_b_out == $past(usb.suspend); endproperty
  a_bs: assert property (p_bs) else $error("b suspend");
  property p_pc;
    ok_ff && $past(cfg_ff[12:8]) == 5'h0a |->
      usb_indicator_b_out == $past(usb.suspend | (usb.high_power & !usb.configured));
  endproperty
  a_pc: assert property (p_pc) else $error("b power class");
  property p_asr; ok_ff && $past(cfg_ff[4:0]) == 5'h02 |-> usb_indicator_a_out == !$past(sr); endproperty
  a_asr: assert property (p_asr) else $error("a suspend or reset");
  property p_as; ok_ff && $past(cfg_ff[4:0]) == 5'h06 |-> usb_indicator_a_out == $past(usb.suspend); endproperty
  a_as: assert property (p_as) else $error("a suspend");
  property p_live;
    bus_req.re && bus_req.addr == SPSC_OFS_INDICATOR |=>
      rd_data[13] == $past(usb_indicator_b_in) && rd_data[5] == $past(usb_indicator_a_in);
  endproperty
  a_live: assert property (p_live) else $error("live level wrong");
  c_susp: cover property ($rose(usb.suspend));
  c_read: cover property (bus_req.re ##1 rd_data != 16'h0000);
  c_pc: cover property (cfg_ff[12:8] == 5'h0a && usb_indicator_b_out);
endmodule // spsc_ctrl_chk
bind spsc_ctrl spsc_ctrl_chk u_chk (.ref_clk, .reset_n, .bus_req, .rd_data, .usb, .normal_pins, .gpio_pins,
  .usb_indicator_a_out, .usb_indicator_a_oe, .usb_indicator_a_in, .usb_indicator_b_out,
  .usb_indicator_b_oe, .usb_indicator_b_in);

// *** tb/test_suspend_pin_and_usb_status_ctrl.sv ***
// Self-checking bench of the suspend pin block.
`timescale 1ns/1ps
module test_suspend_pin_and_usb_status_ctrl
  import spsc_pkg::*;
;
  typedef struct packed {
    logic [15:0] cfg;
    logic [3:0] usb;
    logic [3:0] exp;
  } spsc_row_t;
  // Arbitrary revision value.
  localparam logic [15:0] REV = 16'h5a3c;
  localparam logic [15:0] LVL = 16'h2481;
  localparam logic [15:0] DRV = 16'h8c03;
  localparam logic [15:0] NRM = 16'h2483;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  spsc_bus_req_t bus_req = '0;
  spsc_usb_t usb = '0;
  spsc_pins_t normal_pins = '0;
  spsc_pins_t gpio_pins;
  logic [15:0] rd_data;
  logic usb_indicator_a_out, usb_indicator_a_oe, usb_indicator_a_in;
  logic usb_indicator_b_out, usb_indicator_b_oe, usb_indicator_b_in;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [3:0] e;
  spsc_row_t rows [11] = '{'{16'h0202, 4'h8, 4'h7}, '{16'h0202, 4'h4, 4'h7}, '{16'h0606, 4'h4, 4'h5},
    '{16'h0606, 4'h8, 4'hf}, '{16'h0a0a, 4'h1, 4'hf}, '{16'h0a0a, 4'h3, 4'h5}, '{16'h0a0a, 4'h0, 4'h5},
    '{16'h0101, 4'h0, 4'h1}, '{16'h0101, 4'h8, 4'h4}, '{16'h0909, 4'h0, 4'h5}, '{16'h0505, 4'h8, 4'h0}};
  spsc_ctrl #(.REVISION_VALUE(REV)) uut (.ref_clk, .reset_n, .bus_req, .rd_data, .usb, .normal_pins,
    .gpio_pins, .usb_indicator_a_out, .usb_indicator_a_oe, .usb_indicator_a_in, .usb_indicator_b_out,
    .usb_indicator_b_oe, .usb_indicator_b_in);
  spsc_board board (.a_out(usb_indicator_a_out), .a_oe(usb_indicator_a_oe), .b_out(usb_indicator_b_out),
    .b_oe(usb_indicator_b_oe), .a_in(usb_indicator_a_in), .b_in(usb_indicator_b_in));
  always #10 ref_clk = ~ref_clk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] x);
    @(posedge ref_clk);
    bus_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk);
    bus_req <= '0;
    @(negedge ref_clk);
    chk("rd_data", rd_data, x);
  endtask
  task automatic tick;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 1000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(SPSC_OFS_LEVELS, 16'h0000);
    rd(SPSC_OFS_DRIVE, 16'h0000);
    rd(SPSC_OFS_INDICATOR, 16'h0222);
    wr(SPSC_OFS_REVISION, 16'hffff);
    rd(SPSC_OFS_REVISION, REV);
    rd(10'h100, 16'h0000);
    foreach (rows[i])
    begin
      wr(SPSC_OFS_INDICATOR, rows[i].cfg);
      usb <= spsc_usb_t'(rows[i].usb);
      tick;
      e = rows[i].exp;
      chk("indicators", {usb_indicator_a_out, usb_indicator_a_oe, usb_indicator_b_out, usb_indicator_b_oe}, e);
      rd(SPSC_OFS_INDICATOR, {2'h0, e[0] ? e[1] : 1'b1, rows[i].cfg[12:8], 2'h0, e[2] ? e[3] : 1'b1, rows[i].cfg[4:0]});
    end
    @(posedge ref_clk);
    usb <= '0;
    normal_pins <= '{NRM, 16'h3ccf};
    tick;
    @(posedge ref_clk);
    usb <= spsc_usb_t'(4'h8);
    tick;
    @(posedge ref_clk);
    normal_pins <= '{~NRM, 16'h0000};
    tick;
    tick;
    chk("hold", gpio_pins, {NRM & SPSC_PIN_MASK, 16'h3ccf});
    @(posedge ref_clk);
    usb <= '0;
    tick;
    chk("resume", gpio_pins, {~NRM & SPSC_PIN_MASK, 16'h0000});
    wr(SPSC_OFS_LEVELS, LVL);
    wr(SPSC_OFS_DRIVE, DRV);
    rd(SPSC_OFS_LEVELS, LVL);
    rd(SPSC_OFS_DRIVE, DRV);
    @(posedge ref_clk);
    usb <= spsc_usb_t'(4'h8);
    tick;
    chk("force", gpio_pins, {LVL & ~DRV & SPSC_PIN_MASK, (~DRV | ~LVL) & SPSC_PIN_MASK});
    @(posedge ref_clk);
    usb <= '0;
    reset_n <= 1'b0;
    @(negedge ref_clk);
    chk("reset pins", gpio_pins, 32'h0000_0000);
    chk("reset ind", {usb_indicator_a_out, usb_indicator_a_oe, usb_indicator_b_out, usb_indicator_b_oe}, 4'h0);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(SPSC_OFS_DRIVE, 16'h0000);
    rd(SPSC_OFS_INDICATOR, 16'h0222);
    end_of_test();
  end
endmodule // test_suspend_pin_and_usb_status_ctrl
